/* rtl/gpio_fn.sv */
//==============================================================
// Purpose: analog/digital pin function mux and event gathering
// Assumes: pins and event sources are asynchronous, synced here
// Notes: APB slave answers with zero wait states
//==============================================================
`timescale 1ns/1ps
module gpio_fn
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // transmit reference clocks and enables
   input wire logic tx1_reference_clock_i,
   input wire logic tx2_reference_clock_i,
   input wire logic transmit1_enable_i,
   input wire logic receive1_enable_i,
   input wire logic transmit2_enable_i,
   input wire logic receive2_enable_i,
   // gain words from the gain table
   input wire logic [1:0] rx1_gain_word_i,
   input wire logic [1:0] rx2_gain_word_i,
   // digital pins 12..15 (oe low drives)
   input wire logic [3:0] digital_pin_i,
   output logic [3:0] digital_pin_o,
   output logic [3:0] digital_pin_oe_n_o,
   // analog bank pins (oe low drives)
   input wire logic [11:0] analog_bank_pin_i,
   output logic [11:0] analog_bank_pin_o,
   output logic [11:0] analog_bank_pin_oe_n_o,
   output logic [3:0] auxiliary_voltage_output_en_o,
   // event sources and interrupt
   input wire logic [20:0] event_src_i,
   output logic general_interrupt_out_o
);
   //==============================================================
   // input synchronisers
   logic [11:0] apin_s1_reg, apin_s2_reg;
   logic [3:0] dpin_s1_reg, dpin_s2_reg;
   logic [20:0] evt_s1_reg, evt_s2_reg;
   logic [7:0] ctl_s1_reg, ctl_s2_reg;
   logic [3:0] gw_s1_reg, gw_s2_reg;

   // two flops on every asynchronous input
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         apin_s1_reg <= '0;
         apin_s2_reg <= '0;
         dpin_s1_reg <= '0;
         dpin_s2_reg <= '0;
         evt_s1_reg <= '0;
         evt_s2_reg <= '0;
         ctl_s1_reg <= '0;
         ctl_s2_reg <= '0;
         gw_s1_reg <= '0;
         gw_s2_reg <= '0;
      end
      else
      begin
         apin_s1_reg <= analog_bank_pin_i;
         apin_s2_reg <= apin_s1_reg;
         dpin_s1_reg <= digital_pin_i;
         dpin_s2_reg <= dpin_s1_reg;
         evt_s1_reg <= event_src_i;
         evt_s2_reg <= evt_s1_reg;
         ctl_s1_reg <= {receive2_enable_i, transmit2_enable_i, receive1_enable_i,
            transmit1_enable_i, 2'h0, tx2_reference_clock_i, tx1_reference_clock_i};
         ctl_s2_reg <= ctl_s1_reg;
         gw_s1_reg <= {rx2_gain_word_i, rx1_gain_word_i};
         gw_s2_reg <= gw_s1_reg;
      end
   end

   //==============================================================
   // register file
   logic [24:0] mask_reg, sticky_mask_reg, status_reg;
   logic [6:0] refclk_ctrl_reg;
   logic [2:0] gain_ctrl_reg;
   logic fe_en_reg;
   logic [11:0] man_dir_reg, man_level_reg;
   logic [3:0] aux_en_reg;
   logic wr_go, rd_go;

   assign wr_go = psel_i && penable_i && pwrite_i;
   assign rd_go = psel_i && penable_i && !pwrite_i;

   // software writes; unused mask bits forced to zero
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mask_reg <= gpio_fn_pkg::MASK_RST & gpio_fn_pkg::USED_BITS;
         sticky_mask_reg <= gpio_fn_pkg::MASK_RST & gpio_fn_pkg::USED_BITS;
         refclk_ctrl_reg <= '0;
         gain_ctrl_reg <= '0;
         fe_en_reg <= 1'b0;
         man_dir_reg <= '0;
         man_level_reg <= '0;
         aux_en_reg <= '0;
      end
      else if (wr_go)
      begin
         unique case (paddr_i)
            gpio_fn_pkg::OFF_MASK:
               mask_reg <= pwdata_i[24:0] & gpio_fn_pkg::USED_BITS;
            gpio_fn_pkg::OFF_STICKY_MASK:
               sticky_mask_reg <= pwdata_i[24:0] & gpio_fn_pkg::USED_BITS;
            gpio_fn_pkg::OFF_REFCLK_CTRL: refclk_ctrl_reg <= pwdata_i[6:0];
            gpio_fn_pkg::OFF_GAIN_CTRL: gain_ctrl_reg <= pwdata_i[2:0];
            gpio_fn_pkg::OFF_FE_CTRL: fe_en_reg <= pwdata_i[0];
            gpio_fn_pkg::OFF_MAN_DIR: man_dir_reg <= pwdata_i[11:0];
            gpio_fn_pkg::OFF_MAN_LEVEL: man_level_reg <= pwdata_i[11:0];
            gpio_fn_pkg::OFF_AUX_EN: aux_en_reg <= pwdata_i[3:0];
            default: ;
         endcase
      end
   end

   // status: level of unmasked sources, sticky where sticky mask is clear
   // sticky bits clear when the status register is read; set wins
   logic [24:0] src_vec, status_next;
   logic rd_status;
   assign src_vec = {4'h0, evt_s2_reg};
   assign rd_status = rd_go && (paddr_i == gpio_fn_pkg::OFF_STATUS);
   always_comb
   begin
      status_next = src_vec & ~mask_reg;
      status_next = status_next | (status_reg & ~sticky_mask_reg & ~mask_reg
         & {25{!rd_status}});
      status_next = status_next & gpio_fn_pkg::USED_BITS;
   end
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         status_reg <= '0;
      else
         status_reg <= status_next;
   end

   // interrupt output is OR of unmasked status
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         general_interrupt_out_o <= 1'b0;
      else
         general_interrupt_out_o <= |status_next;
   end

   // apb read mux, zero wait states, unmapped reads zero and error
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         prdata_o <= '0;
         pslverr_o <= 1'b0;
         pready_o <= 1'b0;
      end
      else
      begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         prdata_o <= '0;
         if (psel_i && !penable_i)
         begin
            unique case (paddr_i)
               gpio_fn_pkg::OFF_MASK: prdata_o <= {7'h0, mask_reg};
               gpio_fn_pkg::OFF_STICKY_MASK: prdata_o <= {7'h0, sticky_mask_reg};
               gpio_fn_pkg::OFF_STATUS: prdata_o <= {7'h0, status_next};
               gpio_fn_pkg::OFF_REFCLK_CTRL: prdata_o <= {25'h0, refclk_ctrl_reg};
               gpio_fn_pkg::OFF_GAIN_CTRL: prdata_o <= {29'h0, gain_ctrl_reg};
               gpio_fn_pkg::OFF_FE_CTRL: prdata_o <= {31'h0, fe_en_reg};
               gpio_fn_pkg::OFF_MAN_DIR: prdata_o <= {20'h0, man_dir_reg};
               gpio_fn_pkg::OFF_MAN_LEVEL: prdata_o <= {20'h0, man_level_reg};
               gpio_fn_pkg::OFF_PIN_LEVEL: prdata_o <= {20'h0, apin_s2_reg};
               gpio_fn_pkg::OFF_AUX_EN: prdata_o <= {28'h0, aux_en_reg};
               gpio_fn_pkg::OFF_DPIN_LEVEL: prdata_o <= {28'h0, dpin_s2_reg};
               default: pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   //==============================================================
   // digital pins 12..15: reference clocks or input only
   logic [3:0] dpin_next, dpin_oen_next;
   always_comb
   begin
      dpin_next = '0;
      dpin_oen_next = 4'hF;
      if (refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_EN])
      begin
         dpin_next[0] = ctl_s2_reg[0];
         dpin_next[1] = refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_LVDS] ? !ctl_s2_reg[0]
            : ctl_s2_reg[0];
         if (refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_LVDS])
            dpin_oen_next[1:0] = 2'h0;
         else
            dpin_oen_next[refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_SEL]] = 1'b0;
      end
      if (refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_EN])
      begin
         dpin_next[2] = ctl_s2_reg[1];
         dpin_next[3] = refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_LVDS] ? !ctl_s2_reg[1]
            : ctl_s2_reg[1];
         if (refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_LVDS])
            dpin_oen_next[3:2] = 2'h0;
         else if (refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_SEL])
            dpin_oen_next[3] = 1'b0;
         else
            dpin_oen_next[2] = 1'b0;
      end
   end

   //==============================================================
   // analog pins: manual, then gain word, then front-end, aux on top
   logic [11:0] apin_next, apin_oen_next;
   logic [1:0] nib_sel;
   always_comb
   begin
      apin_next = man_level_reg;
      apin_oen_next = ~man_dir_reg;
      nib_sel = fe_en_reg ? gpio_fn_pkg::NIB_MID
         : gain_ctrl_reg[gpio_fn_pkg::GC_NIB_LO +: 2];
      if (gain_ctrl_reg[gpio_fn_pkg::GC_EN])
      begin
         unique case (nib_sel)
            gpio_fn_pkg::NIB_LOW:
            begin
               apin_next[3:0] = gw_s2_reg;
               apin_oen_next[3:0] = 4'h0;
            end
            gpio_fn_pkg::NIB_MID:
            begin
               apin_next[7:4] = gw_s2_reg;
               apin_oen_next[7:4] = 4'h0;
            end
            gpio_fn_pkg::NIB_HIGH:
            begin
               apin_next[11:8] = gw_s2_reg;
               apin_oen_next[11:8] = 4'h0;
            end
            default: ;
         endcase
      end
      if (fe_en_reg)
      begin
         apin_next[gpio_fn_pkg::FE_TX1_PIN] = ctl_s2_reg[4];
         apin_next[gpio_fn_pkg::FE_RX1_PIN] = ctl_s2_reg[5];
         apin_next[gpio_fn_pkg::FE_TX2_PIN] = ctl_s2_reg[6];
         apin_next[gpio_fn_pkg::FE_RX2_PIN] = ctl_s2_reg[7];
         apin_oen_next[gpio_fn_pkg::FE_TX1_PIN] = 1'b0;
         apin_oen_next[gpio_fn_pkg::FE_RX1_PIN] = 1'b0;
         apin_oen_next[gpio_fn_pkg::FE_TX2_PIN] = 1'b0;
         apin_oen_next[gpio_fn_pkg::FE_RX2_PIN] = 1'b0;
      end
      // aux output owns pin: digital driver off
      for (int i = 0; i < gpio_fn_pkg::NAUX; i++)
      begin
         if (aux_en_reg[i])
         begin
            apin_next[i] = 1'b0;
            apin_oen_next[i] = 1'b1;
         end
      end
   end

   // pin outputs registered
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         digital_pin_o <= '0;
         digital_pin_oe_n_o <= 4'hF;
         analog_bank_pin_o <= '0;
         analog_bank_pin_oe_n_o <= 12'hFFF;
         auxiliary_voltage_output_en_o <= '0;
      end
      else
      begin
         digital_pin_o <= dpin_next;
         digital_pin_oe_n_o <= dpin_oen_next;
         analog_bank_pin_o <= apin_next;
         analog_bank_pin_oe_n_o <= apin_oen_next;
         auxiliary_voltage_output_en_o <= aux_en_reg;
      end
   end

   //==============================================================
   // assertions
   // status is built from the mask of the edge before, so compare against that mask
   AST_MASK_BLOCKS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (status_reg & $past(mask_reg)) == '0) else $error("masked bit in status");
   AST_INT_OR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      general_interrupt_out_o == |status_reg) else $error("int not OR");
   AST_UNUSED_ZERO: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      status_reg[24:21] == 4'h0 && mask_reg[24:21] == 4'h0)
      else $error("unused bits set");
   AST_EVT_MAP: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (evt_s2_reg[0] && !mask_reg[0]) |=> status_reg[0])
      else $error("event not reported");
   AST_DPIN_INPUT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (!refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_EN]) |=> digital_pin_oe_n_o[1:0] == 2'h3)
      else $error("dpin driven while disabled");
   AST_DPIN2_INPUT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (!refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_EN]) |=> digital_pin_oe_n_o[3:2] == 2'h3)
      else $error("tx2 dpin driven while disabled");
   AST_TX1_LVDS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_EN] && refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_LVDS])
      |=> digital_pin_oe_n_o[1:0] == 2'h0 && digital_pin_o[1] != digital_pin_o[0])
      else $error("tx1 lvds bad");
   AST_TX2_LVDS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_EN] && refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_LVDS])
      |=> digital_pin_oe_n_o[3:2] == 2'h0)
      else $error("tx2 lvds bad");
   // cmos mode drives exactly one pin of the pair
   AST_TX2_CMOS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_EN] && !refclk_ctrl_reg[gpio_fn_pkg::RC_TX2_LVDS])
      |=> digital_pin_oe_n_o[3] != digital_pin_oe_n_o[2])
      else $error("tx2 cmos bad");
   AST_FE_PIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (fe_en_reg && !aux_en_reg[0]) |=> analog_bank_pin_o[0] == $past(ctl_s2_reg[4]))
      else $error("front-end pin wrong");
   AST_FE_RX2: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      fe_en_reg |=> analog_bank_pin_o[gpio_fn_pkg::FE_RX2_PIN] == $past(ctl_s2_reg[7])
      && analog_bank_pin_oe_n_o[gpio_fn_pkg::FE_RX2_PIN] == 1'b0)
      else $error("rx2 front-end pin wrong");
   AST_AUX_WINS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      aux_en_reg[1] |=> analog_bank_pin_oe_n_o[1]) else $error("aux not override");
   AST_FE_GAIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (fe_en_reg && gain_ctrl_reg[gpio_fn_pkg::GC_EN])
      |=> analog_bank_pin_o[7:4] == $past(gw_s2_reg))
      else $error("gain word misplaced");
   AST_GAIN_LOW: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (gain_ctrl_reg[gpio_fn_pkg::GC_EN] && !fe_en_reg && aux_en_reg == '0
      && gain_ctrl_reg[gpio_fn_pkg::GC_NIB_LO +: 2] == gpio_fn_pkg::NIB_LOW)
      |=> analog_bank_pin_oe_n_o[3:0] == 4'h0 && analog_bank_pin_o[3:0] == $past(gw_s2_reg))
      else $error("gain word not in low nibble");
   COV_INT: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(general_interrupt_out_o));
   COV_AUX: cover property (@(posedge mclk_i) disable iff (!nrst_i) aux_en_reg[0]);
   COV_FE: cover property (@(posedge mclk_i) disable iff (!nrst_i) fe_en_reg);
   COV_LVDS: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_EN] && refclk_ctrl_reg[gpio_fn_pkg::RC_TX1_LVDS]);
   COV_STICKY_CLR: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      rd_status && |(status_reg & ~sticky_mask_reg));
endmodule // gpio_fn

/* shared/gpio_fn_pkg.sv */
//==============================================================
// Purpose: constants for the pin-function and event block
// Assumes: 32-bit APB, 200 MHz mclk_i
// Notes: register offsets are byte addresses
//==============================================================
package gpio_fn_pkg;
   localparam int unsigned AW = 12;
   localparam int unsigned NSRC = 25;
   localparam int unsigned NUSED = 21;
   localparam int unsigned NAPIN = 12;
   localparam int unsigned NDPIN = 4;
   // register byte offsets
   localparam logic [AW-1:0] OFF_MASK = 12'h000;
   localparam logic [AW-1:0] OFF_STICKY_MASK = 12'h004;
   localparam logic [AW-1:0] OFF_STATUS = 12'h008;
   localparam logic [AW-1:0] OFF_REFCLK_CTRL = 12'h00C;
   localparam logic [AW-1:0] OFF_GAIN_CTRL = 12'h010;
   localparam logic [AW-1:0] OFF_FE_CTRL = 12'h014;
   localparam logic [AW-1:0] OFF_MAN_DIR = 12'h018;
   localparam logic [AW-1:0] OFF_MAN_LEVEL = 12'h01C;
   localparam logic [AW-1:0] OFF_PIN_LEVEL = 12'h020;
   localparam logic [AW-1:0] OFF_AUX_EN = 12'h024;
   localparam logic [AW-1:0] OFF_DPIN_LEVEL = 12'h028;
   // reset values and used-bit mask
   localparam logic [NSRC-1:0] MASK_RST = 25'h1FFFFFF;
   localparam logic [NSRC-1:0] USED_BITS = 25'h01FFFFF;
   // refclk ctrl fields: [0] tx1 en [1] tx1 lvds [2] tx1 cmos pin sel
   // [4] tx2 en [5] tx2 lvds [6] tx2 cmos pin sel
   localparam int unsigned RC_TX1_EN = 0;
   localparam int unsigned RC_TX1_LVDS = 1;
   localparam int unsigned RC_TX1_SEL = 2;
   localparam int unsigned RC_TX2_EN = 4;
   localparam int unsigned RC_TX2_LVDS = 5;
   localparam int unsigned RC_TX2_SEL = 6;
   // gain ctrl fields: [0] enable, [2:1] nibble select
   localparam int unsigned GC_EN = 0;
   localparam int unsigned GC_NIB_LO = 1;
   localparam logic [1:0] NIB_LOW = 2'h0;
   localparam logic [1:0] NIB_MID = 2'h1;
   localparam logic [1:0] NIB_HIGH = 2'h2;
   // analog pins used for front-end control
   localparam int unsigned FE_TX1_PIN = 0;
   localparam int unsigned FE_RX1_PIN = 1;
   localparam int unsigned FE_TX2_PIN = 8;
   localparam int unsigned FE_RX2_PIN = 9;
   localparam int unsigned NAUX = 4;
endpackage

/* bench/far_side_model.sv */
//==============================================================
// Purpose: far side of the pins: host clocks and outside drivers
// Assumes: the bench picks the outside level of undriven analog pins
// Notes: an analog wire follows the design only where its oe_n is low; a released digital wire shows the inverse of the design's output
//==============================================================
`timescale 1ns/1ps
module far_side_model
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // design pin side
   input wire logic [3:0] dpin_out_i,
   input wire logic [3:0] dpin_oe_n_i,
   input wire logic [11:0] apin_out_i,
   input wire logic [11:0] apin_oe_n_i,
   input wire logic [11:0] ext_level_i,
   // toward the design
   output logic tx1_clk_o,
   output logic tx2_clk_o,
   output logic [3:0] dpin_wire_o,
   output logic [11:0] apin_wire_o
);
   logic [1:0] div_reg;
   // reference clocks at a half and a quarter of mclk
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         div_reg <= 2'h0;
      else
         div_reg <= div_reg + 2'h1;
   end
   assign tx1_clk_o = div_reg[0];
   assign tx2_clk_o = div_reg[1];
   // released digital pins show the inverse of the design's output level
   assign dpin_wire_o = (dpin_oe_n_i & ~dpin_out_i) | (~dpin_oe_n_i & dpin_out_i);
   assign apin_wire_o = (apin_oe_n_i & ext_level_i) | (~apin_oe_n_i & apin_out_i);
endmodule // far_side_model

/* bench/gpio_function_and_interrupt_tb.sv */
//==============================================================
// Purpose: self-checking bench of the pin-function and event block
// Assumes: zero-wait APB slave, about 3 edges from input to pin
// Notes: settle waits 6 cycles to cover sync plus output flop
//==============================================================
`timescale 1ns/1ps
module gpio_function_and_interrupt_tb;
   logic mclk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, aw, aout, aoen, ext;
   logic [31:0] pwdata, prdata, rd;
   logic tx1c, tx2c, t1en, r1en, t2en, r2en, irq, err;
   logic [1:0] g1, g2;
   logic [3:0] dw, dout, doen, auxen;
   logic [20:0] ev;
   int err_total, n_checks, cyc;
   localparam logic [31:0] USED = 32'(gpio_fn_pkg::USED_BITS);
   //==============================================================
   // design, far side and clock
   gpio_fn DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .tx1_reference_clock_i(tx1c),
      .tx2_reference_clock_i(tx2c), .transmit1_enable_i(t1en), .receive1_enable_i(r1en),
      .transmit2_enable_i(t2en), .receive2_enable_i(r2en), .rx1_gain_word_i(g1),
      .rx2_gain_word_i(g2), .digital_pin_i(dw), .digital_pin_o(dout),
      .digital_pin_oe_n_o(doen), .analog_bank_pin_i(aw), .analog_bank_pin_o(aout),
      .analog_bank_pin_oe_n_o(aoen), .auxiliary_voltage_output_en_o(auxen),
      .event_src_i(ev), .general_interrupt_out_o(irq));
   far_side_model fsm (.mclk_i(mclk_i), .nrst_i(nrst_i), .dpin_out_i(dout), .dpin_oe_n_i(doen),
      .apin_out_i(aout), .apin_oe_n_i(aoen), .ext_level_i(ext), .tx1_clk_o(tx1c),
      .tx2_clk_o(tx2c), .dpin_wire_o(dw), .apin_wire_o(aw));
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   //==============================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      @(posedge mclk_i);
      // wait for the answer; only the bench timeout ends a hung wait
      while (pready !== 1'b1)
      begin
         @(posedge mclk_i);
         n++;
      end
      rd = prdata;
      err = pslverr;
      chk(32'(n), 32'h0, "apb wait states");
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next setup never re-drives psel in this step
      @(posedge mclk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   task automatic settle();
      repeat (6) @(posedge mclk_i);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   //==============================================================
   // scenarios
   task automatic t_reset();
      chk(32'(aoen), 32'h0FFF, "analog oe_n idle");
      chk(32'(doen), 32'h000F, "digital oe_n idle");
      rdchk(gpio_fn_pkg::OFF_MASK, USED, "mask reset");
      rdchk(gpio_fn_pkg::OFF_STATUS, 32'h0, "status reset");
      rdchk(12'h100, 32'h0, "unmapped read");
      chk(32'(err), 32'h1, "unmapped error");
      $display("test reset done");
   endtask
   task automatic t_events();
      wr(gpio_fn_pkg::OFF_STICKY_MASK, USED);
      ev <= 21'h1FFFFF;
      for (int i = 0; i < 21; i++)
      begin
         wr(gpio_fn_pkg::OFF_MASK, ~(32'h1 << i));
         settle();
         rdchk(gpio_fn_pkg::OFF_STATUS, 32'h1 << i, "status bit");
         chk(32'(irq), 32'h1, "irq on");
      end
      wr(gpio_fn_pkg::OFF_MASK, 32'hFFFFFFFF);
      settle();
      chk(32'(irq), 32'h0, "irq masked");
      rdchk(gpio_fn_pkg::OFF_MASK, USED, "mask width");
      ev <= 21'h0;
      wr(gpio_fn_pkg::OFF_STICKY_MASK, 32'h0);
      wr(gpio_fn_pkg::OFF_MASK, 32'h0);
      rdchk(gpio_fn_pkg::OFF_STICKY_MASK, 32'h0, "sticky mask rw");
      // status is unmasked and idle here, so a stored write would show
      wr(gpio_fn_pkg::OFF_STATUS, 32'hFFFFFFFF);
      rdchk(gpio_fn_pkg::OFF_STATUS, 32'h0, "status write ignored");
      ev <= 21'h20;
      repeat (4) @(posedge mclk_i);
      ev <= 21'h0;
      for (int n = 0; n < 20 && irq !== 1'b1; n++)
         @(posedge mclk_i);
      settle();
      rdchk(gpio_fn_pkg::OFF_STATUS, 32'h20, "sticky cause");
      rdchk(gpio_fn_pkg::OFF_STATUS, 32'h0, "sticky cleared");
      settle();
      chk(32'(irq), 32'h0, "irq cleared");
      $display("test events done");
   endtask
   task automatic t_refclk();
      logic [3:0] m;
      for (int c = 0; c < 2; c++)
         for (int k = 0; k < 3; k++)
         begin
            m = (k == 0) ? 4'h3 : (k == 1) ? 4'h1 : 4'h2;
            wr(gpio_fn_pkg::OFF_REFCLK_CTRL,
               (32'h1 | 32'(k == 0) << 1 | 32'(k == 2) << 2) << 4 * c);
            settle();
            chk(32'(doen), 32'(4'(~(m << 2 * c))), "refclk oe_n");
            if (k == 0)
               repeat (3)
               begin
                  chk(32'(dout[2 * c + 1]), 32'(!dout[2 * c]), "lvds pair");
                  @(posedge mclk_i);
               end
         end
      wr(gpio_fn_pkg::OFF_REFCLK_CTRL, 32'h0);
      settle();
      chk(32'(doen), 32'hF, "refclk off");
      rdchk(gpio_fn_pkg::OFF_DPIN_LEVEL, 32'hF, "digital pin levels");
      $display("test refclk done");
   endtask
   task automatic t_analog();
      g1 <= 2'h2;
      g2 <= 2'h1;
      for (int n = 0; n < 3; n++)
      begin
         wr(gpio_fn_pkg::OFF_GAIN_CTRL, 32'h1 | n << 1);
         settle();
         chk(32'(aoen), 32'(12'(~(12'hF << 4 * n))), "gain oe_n");
         chk(32'(aout[4 * n +: 4]), 32'h6, "gain word");
      end
      wr(gpio_fn_pkg::OFF_GAIN_CTRL, 32'h1);
      wr(gpio_fn_pkg::OFF_FE_CTRL, 32'h1);
      for (int s = 0; s < 2; s++)
      begin
         {t1en, r1en, t2en, r2en} <= s ? 4'h6 : 4'h9;
         settle();
         chk(32'(aoen), 32'h0C0C, "fe oe_n");
         chk(32'({aout[9:8], aout[7:4], aout[1:0]}), s ? 32'h5A : 32'h99, "fe pins");
      end
      wr(gpio_fn_pkg::OFF_AUX_EN, 32'h3);
      settle();
      chk(32'({auxen, aoen[1:0], aout[1:0]}), 32'h3C, "aux override");
      wr(gpio_fn_pkg::OFF_AUX_EN, 32'h0);
      settle();
      chk(32'({auxen, aoen[1:0], aout[1:0]}), 32'h2, "aux released");
      wr(gpio_fn_pkg::OFF_FE_CTRL, 32'h0);
      wr(gpio_fn_pkg::OFF_GAIN_CTRL, 32'h0);
      wr(gpio_fn_pkg::OFF_MAN_DIR, 32'h0F0);
      wr(gpio_fn_pkg::OFF_MAN_LEVEL, 32'h0A0);
      ext <= 12'h3C3;
      settle();
      chk(32'(aoen), 32'h0F0F, "manual dir");
      rdchk(gpio_fn_pkg::OFF_PIN_LEVEL, 32'h3A3, "pin levels");
      $display("test analog done");
   endtask
   //==============================================================
   // timeout and main sequence
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         summarize();
      end
   end
   initial
   begin
      {nrst_i, psel, penable, pwrite, t1en, r1en, t2en, r2en} = 8'h0;
      {paddr, ext, g1, g2, ev, pwdata} = '0;
      {err_total, n_checks, cyc} = '0;
      repeat (8) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      t_reset();
      t_events();
      t_refclk();
      t_analog();
      summarize();
   end
endmodule // gpio_function_and_interrupt_tb
